// ---- hw/sensorless_bldc_startup.sv ----
// Start-up sequencer: spin check, rotor position probe or alignment, hand-off
//
// What this block does
// - Fast spinning motor: all switches off, coast.
// - After coasting, brake with every low-side gate.
// - Six probe pulses, one measurement each.
// - Fastest rising drive state marks rotor.
// - Pulse order alternates to oppose rotation.
// - Six equal sixty-degree drive states per revolution.
// - Neighbour comparison narrows to half segment.
// - Initial state leads rotor by ninety degrees.
// - Timed pulse; timer expiry triggers ADC.
// - Current sampled after pulse withdrawn.
// - Pulse end: high-side off, low-side on.
// - After brake interval, low-side off: coast.
// - Next pulse waits for coast completion.
// - Hand chosen initial state to open loop.
// - Alignment drives exactly two phases, high/low, for states 0 to 5; 6 and 7 drive none.
// - Alignment: off, settle, then start up.
// - Brake only below configurable voltage threshold.
// - Spin brake time counted in milliseconds.
`timescale 1ns/1ps

module sensorless_bldc_startup #(
  parameter int unsigned MS_TICK_CYCLES = bldc_startup_pkg::MS_TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  input wire logic [11:0] back_voltage_i,
  input wire logic back_voltage_valid_i,
  input wire logic [11:0] phase_current_i,
  input wire logic phase_current_valid_i,
  output logic adc_trigger_o,
  output logic [2:0] high_gate_o,
  output logic [2:0] low_gate_o,
  output logic busy_o,
  output logic handoff_valid_o,
  output logic [2:0] handoff_state_o
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    bldc_startup_pkg::seq_state_type st;
    logic [11:0] thresh;
    logic [15:0] brake_ms;
    logic [15:0] pulse_cfg;
    logic [15:0] pbrake_cfg;
    logic [15:0] pcoast_cfg;
    logic [23:0] align_cfg;
    logic [23:0] settle_cfg;
    logic [17:0] order;
    logic [2:0] align_st;
    logic mode_align;
    logic spin_en;
    logic [16:0] ms_cnt;
    logic [15:0] ms_done;
    logic [15:0] pulse_cnt;
    logic [15:0] pbrake_cnt;
    logic [15:0] pcoast_cnt;
    logic [23:0] align_cnt;
    logic [2:0] slot;
    logic [2:0] cur;
    logic sampled;
    logic [5:0][11:0] rise;
    logic done;
    logic [2:0] hs;
    logic [2:0] ls;
    logic adc_trigger;
    logic handoff_valid;
    logic [2:0] handoff_state;
    logic [31:0] rd_data;
    logic busy;
  } state_type;

  // Drive state k: high phase and low phase, one sixty-degree segment each
  function automatic logic [5:0] drive_mask(input logic [2:0] k);
    case (k)
      3'h0: drive_mask = {3'h1, 3'h2};
      3'h1: drive_mask = {3'h1, 3'h4};
      3'h2: drive_mask = {3'h2, 3'h4};
      3'h3: drive_mask = {3'h2, 3'h1};
      3'h4: drive_mask = {3'h4, 3'h1};
      3'h5: drive_mask = {3'h4, 3'h2};
      default: drive_mask = 6'h00;
    endcase
  endfunction : drive_mask

  // Counter reaches its configured length; a zero length acts as one
  function automatic logic expired(input logic [23:0] cnt, input logic [23:0] cfg);
    expired = ({1'b0, cnt} + 25'h0000001) >= {1'b0, cfg};
  endfunction : expired

  function automatic logic [2:0] wrap6(input logic [3:0] v);
    wrap6 = (v >= 4'h6) ? 3'(v - 4'h6) : v[2:0];
  endfunction : wrap6

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  state_type r;
  state_type next_r;
  logic ms_tick;
  logic start_req;
  logic [2:0] slot_state;
  logic [2:0] best;
  logic [2:0] prev_n;
  logic [2:0] next_n;
  logic [3:0] half_pos;
  logic [2:0] init_st;

  always_comb
  begin
    next_r = r;
    next_r.adc_trigger = 1'b0;
    next_r.handoff_valid = 1'b0;
    next_r.rd_data = 32'h00000000;
    ms_tick = (32'(r.ms_cnt) + 32'h1) >= MS_TICK_CYCLES;
    next_r.ms_cnt = ms_tick ? 17'h00000 : r.ms_cnt + 17'h00001;
    start_req = wr_i && (addr_i == bldc_startup_pkg::REG_CTRL)
      && wr_data_i[bldc_startup_pkg::CTRL_START_BIT];
    slot_state = r.order[3 * r.slot +: 3];
    if (slot_state > 3'h5)
    begin
      slot_state = r.slot;
    end
    best = 3'h0;
    for (int i = 1; i < bldc_startup_pkg::NUM_STATES; i++)
    begin
      if (r.rise[i] > r.rise[best])
      begin
        best = 3'(i);
      end
    end
    prev_n = wrap6({1'b0, best} + 4'h5);
    next_n = wrap6({1'b0, best} + 4'h1);
    half_pos = {best, 1'b0} + {3'h0, r.rise[next_n] > r.rise[prev_n]};
    init_st = wrap6(4'((5'(half_pos) + 5'h03) >> 1));

    // Register writes; configuration is locked while a start-up runs
    if (wr_i && !busy_o)
    begin
      case (addr_i)
        bldc_startup_pkg::REG_CTRL:
        begin
          next_r.mode_align = wr_data_i[bldc_startup_pkg::CTRL_ALIGN_BIT];
          next_r.spin_en = wr_data_i[bldc_startup_pkg::CTRL_SPIN_EN_BIT];
          next_r.align_st = wr_data_i[bldc_startup_pkg::CTRL_ALIGN_ST_LSB +: 3];
        end
        bldc_startup_pkg::REG_COAST_THRESH: next_r.thresh = wr_data_i[11:0];
        bldc_startup_pkg::REG_BRAKE_MS: next_r.brake_ms = wr_data_i[15:0];
        bldc_startup_pkg::REG_PULSE_CYC: next_r.pulse_cfg = wr_data_i[15:0];
        bldc_startup_pkg::REG_PBRAKE_CYC: next_r.pbrake_cfg = wr_data_i[15:0];
        bldc_startup_pkg::REG_PCOAST_CYC: next_r.pcoast_cfg = wr_data_i[15:0];
        bldc_startup_pkg::REG_ALIGN_CYC: next_r.align_cfg = wr_data_i[23:0];
        bldc_startup_pkg::REG_SETTLE_CYC: next_r.settle_cfg = wr_data_i[23:0];
        bldc_startup_pkg::REG_ORDER: next_r.order = wr_data_i[17:0];
        default: ;
      endcase
    end

    // Register reads, answered in the following cycle
    if (rd_i)
    begin
      case (addr_i)
        bldc_startup_pkg::REG_CTRL: next_r.rd_data = {25'h0, r.align_st, 1'b0,
          r.spin_en, r.mode_align, 1'b0};
        bldc_startup_pkg::REG_STATUS: next_r.rd_data = {13'h0, r.st, 1'b0,
          r.handoff_state, 2'h0, r.done, busy_o};
        bldc_startup_pkg::REG_COAST_THRESH: next_r.rd_data = {20'h0, r.thresh};
        bldc_startup_pkg::REG_BRAKE_MS: next_r.rd_data = {16'h0, r.brake_ms};
        bldc_startup_pkg::REG_PULSE_CYC: next_r.rd_data = {16'h0, r.pulse_cfg};
        bldc_startup_pkg::REG_PBRAKE_CYC: next_r.rd_data = {16'h0, r.pbrake_cfg};
        bldc_startup_pkg::REG_PCOAST_CYC: next_r.rd_data = {16'h0, r.pcoast_cfg};
        bldc_startup_pkg::REG_ALIGN_CYC: next_r.rd_data = {8'h0, r.align_cfg};
        bldc_startup_pkg::REG_SETTLE_CYC: next_r.rd_data = {8'h0, r.settle_cfg};
        bldc_startup_pkg::REG_ORDER: next_r.rd_data = {14'h0, r.order};
        default:
        begin
          if (addr_i >= bldc_startup_pkg::REG_RISE0
            && addr_i < bldc_startup_pkg::REG_RISE0 + 8'h06)
          begin
            next_r.rd_data = {20'h0, r.rise[3'(addr_i - bldc_startup_pkg::REG_RISE0)]};
          end
        end
      endcase
    end

    case (r.st)
      bldc_startup_pkg::ST_IDLE, bldc_startup_pkg::ST_DONE:
      begin
        next_r.hs = 3'h0;
        next_r.ls = 3'h0;
        if (start_req)
        begin
          next_r.done = 1'b0;
          next_r.slot = 3'h0;
          next_r.sampled = 1'b0;
          next_r.pulse_cnt = 16'h0000;
          next_r.align_cnt = 24'h000000;
          if (wr_data_i[bldc_startup_pkg::CTRL_SPIN_EN_BIT])
          begin
            next_r.st = bldc_startup_pkg::ST_SPIN_COAST;
          end
          else if (wr_data_i[bldc_startup_pkg::CTRL_ALIGN_BIT])
          begin
            next_r.st = bldc_startup_pkg::ST_ALIGN_DRIVE;
          end
          else
          begin
            next_r.st = bldc_startup_pkg::ST_PROBE_PULSE;
          end
        end
      end
      bldc_startup_pkg::ST_SPIN_COAST:
      begin
        next_r.hs = 3'h0;
        next_r.ls = 3'h0;
        if (back_voltage_valid_i && back_voltage_i < r.thresh)
        begin
          next_r.st = bldc_startup_pkg::ST_SPIN_BRAKE;
          next_r.ms_done = 16'h0000;
          next_r.ms_cnt = 17'h00000;
        end
      end
      bldc_startup_pkg::ST_SPIN_BRAKE:
      begin
        next_r.hs = 3'h0;
        next_r.ls = 3'h7;
        if (ms_tick)
        begin
          next_r.ms_done = r.ms_done + 16'h0001;
        end
        if (r.ms_done >= r.brake_ms)
        begin
          next_r.ls = 3'h0;
          next_r.st = r.mode_align ? bldc_startup_pkg::ST_ALIGN_DRIVE
            : bldc_startup_pkg::ST_PROBE_PULSE;
        end
      end
      bldc_startup_pkg::ST_PROBE_PULSE:
      begin
        next_r.cur = slot_state;
        {next_r.hs, next_r.ls} = drive_mask(slot_state);
        next_r.pulse_cnt = r.pulse_cnt + 16'h0001;
        // Count starts while gates are still off, so expiry is one count later
        if (r.pulse_cnt != 16'h0000
          && expired({8'h0, r.pulse_cnt - 16'h0001}, {8'h0, r.pulse_cfg}))
        begin
          // Withdraw the pulse and trigger the ADC on the same edge
          next_r.hs = 3'h0;
          next_r.adc_trigger = 1'b1;
          next_r.sampled = 1'b0;
          next_r.pbrake_cnt = 16'h0000;
          next_r.st = bldc_startup_pkg::ST_PROBE_BRAKE;
        end
      end
      bldc_startup_pkg::ST_PROBE_BRAKE:
      begin
        next_r.hs = 3'h0;
        next_r.pbrake_cnt = r.pbrake_cnt + 16'h0001;
        if (expired({8'h0, r.pbrake_cnt}, {8'h0, r.pbrake_cfg}))
        begin
          next_r.ls = 3'h0;
          next_r.pcoast_cnt = 16'h0000;
          next_r.st = bldc_startup_pkg::ST_PROBE_COAST;
        end
      end
      bldc_startup_pkg::ST_PROBE_COAST:
      begin
        next_r.hs = 3'h0;
        next_r.ls = 3'h0;
        if (!expired({8'h0, r.pcoast_cnt}, {8'h0, r.pcoast_cfg}))
        begin
          next_r.pcoast_cnt = r.pcoast_cnt + 16'h0001;
        end
        else if (r.sampled)
        begin
          next_r.pulse_cnt = 16'h0000;
          next_r.slot = r.slot + 3'h1;
          next_r.st = (r.slot == 3'h5) ? bldc_startup_pkg::ST_EVALUATE
            : bldc_startup_pkg::ST_PROBE_PULSE;
        end
      end
      bldc_startup_pkg::ST_EVALUATE:
      begin
        next_r.handoff_state = init_st;
        next_r.st = bldc_startup_pkg::ST_HANDOFF;
      end
      bldc_startup_pkg::ST_ALIGN_DRIVE:
      begin
        {next_r.hs, next_r.ls} = drive_mask(r.align_st);
        next_r.align_cnt = r.align_cnt + 24'h000001;
        if (r.align_cnt != 24'h000000 && expired(r.align_cnt - 24'h000001, r.align_cfg))
        begin
          next_r.hs = 3'h0;
          next_r.ls = 3'h0;
          next_r.align_cnt = 24'h000000;
          next_r.st = bldc_startup_pkg::ST_ALIGN_SETTLE;
        end
      end
      bldc_startup_pkg::ST_ALIGN_SETTLE:
      begin
        next_r.align_cnt = r.align_cnt + 24'h000001;
        if (expired(r.align_cnt, r.settle_cfg))
        begin
          // Rotor sits mid-segment of the aligned state
          next_r.handoff_state = wrap6(4'((5'({r.align_st, 1'b1}) + 5'h03) >> 1));
          next_r.st = bldc_startup_pkg::ST_HANDOFF;
        end
      end
      bldc_startup_pkg::ST_HANDOFF:
      begin
        next_r.handoff_valid = 1'b1;
        next_r.done = 1'b1;
        next_r.st = bldc_startup_pkg::ST_DONE;
      end
      default: next_r.st = bldc_startup_pkg::ST_IDLE;
    endcase

    // Late samples still land; the coast exit waits for this flag
    if (phase_current_valid_i && !r.sampled
      && (r.st == bldc_startup_pkg::ST_PROBE_BRAKE || r.st == bldc_startup_pkg::ST_PROBE_COAST))
    begin
      next_r.rise[r.cur] = phase_current_i;
      next_r.sampled = 1'b1;
    end
    next_r.busy = !(next_r.st == bldc_startup_pkg::ST_IDLE
      || next_r.st == bldc_startup_pkg::ST_DONE);
  end

  always_ff @(posedge mclk_i or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      r <= '0;
      r.st <= bldc_startup_pkg::ST_IDLE;
      r.thresh <= bldc_startup_pkg::RST_COAST_THRESH;
      r.brake_ms <= bldc_startup_pkg::RST_BRAKE_MS;
      r.pulse_cfg <= bldc_startup_pkg::RST_PULSE_CYC;
      r.pbrake_cfg <= bldc_startup_pkg::RST_PBRAKE_CYC;
      r.pcoast_cfg <= bldc_startup_pkg::RST_PCOAST_CYC;
      r.align_cfg <= bldc_startup_pkg::RST_ALIGN_CYC;
      r.settle_cfg <= bldc_startup_pkg::RST_SETTLE_CYC;
      r.order <= bldc_startup_pkg::RST_ORDER;
      {r.spin_en, r.mode_align} <= bldc_startup_pkg::RST_CTRL[2:1];
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o = r.rd_data;
  assign adc_trigger_o = r.adc_trigger;
  assign high_gate_o = r.hs;
  assign low_gate_o = r.ls;
  assign busy_o = r.busy;
  assign handoff_valid_o = r.handoff_valid;
  assign handoff_state_o = r.handoff_state;

endmodule : sensorless_bldc_startup

// ---- pkg/bldc_startup_pkg.sv ----
// Constants, register map and state codes of the sensorless start-up sequencer
package bldc_startup_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_PERIOD_NS = 1000000;
  localparam int unsigned MS_TICK_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_COAST_THRESH = 8'h02;
  localparam logic [7:0] REG_BRAKE_MS = 8'h03;
  localparam logic [7:0] REG_PULSE_CYC = 8'h04;
  localparam logic [7:0] REG_PBRAKE_CYC = 8'h05;
  localparam logic [7:0] REG_PCOAST_CYC = 8'h06;
  localparam logic [7:0] REG_ALIGN_CYC = 8'h07;
  localparam logic [7:0] REG_SETTLE_CYC = 8'h08;
  localparam logic [7:0] REG_ORDER = 8'h09;
  localparam logic [7:0] REG_RISE0 = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_ALIGN_BIT = 1;
  localparam int unsigned CTRL_SPIN_EN_BIT = 2;
  localparam int unsigned CTRL_ALIGN_ST_LSB = 4;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_INIT_LSB = 4;
  localparam int unsigned STAT_STATE_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_COAST_THRESH = 12'h046;
  localparam logic [15:0] RST_BRAKE_MS = 16'h001e;
  localparam logic [15:0] RST_PULSE_CYC = 16'h0bb8;
  localparam logic [15:0] RST_PBRAKE_CYC = 16'h001e;
  localparam logic [15:0] RST_PCOAST_CYC = 16'h03e8;
  localparam logic [23:0] RST_ALIGN_CYC = 24'h0f4240;
  localparam logic [23:0] RST_SETTLE_CYC = 24'h07a120;
  // Alternating default: slots run 0,3,1,4,2,5, so each second pulse faces the opposite of the one before
  localparam logic [17:0] RST_ORDER = {3'h5, 3'h2, 3'h4, 3'h1, 3'h3, 3'h0};
  localparam logic [2:0] RST_CTRL = 3'h4;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_STATES = 6;
  localparam int unsigned ADC_W = 12;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_SPIN_COAST = 11'h002,
    ST_SPIN_BRAKE = 11'h004,
    ST_PROBE_PULSE = 11'h008,
    ST_PROBE_BRAKE = 11'h010,
    ST_PROBE_COAST = 11'h020,
    ST_EVALUATE = 11'h040,
    ST_ALIGN_DRIVE = 11'h080,
    ST_ALIGN_SETTLE = 11'h100,
    ST_DONE = 11'h200,
    ST_HANDOFF = 11'h400
  } seq_state_type;

endpackage : bldc_startup_pkg

// ---- verif/motor_power_stage.sv ----
// Behavioural power stage: gate decode, delayed current sample, back voltage
`timescale 1ns/1ps

module motor_power_stage (
  input wire logic mclk_i,
  input wire logic [2:0] high_gate_i,
  input wire logic [2:0] low_gate_i,
  input wire logic adc_trigger_i,
  input wire logic [5:0][11:0] cur_tbl_i,
  input wire logic [7:0] delay_i,
  input wire logic [11:0] bv_level_i,
  output logic [11:0] phase_current_o = 12'h000,
  output logic phase_current_valid_o = 1'b0,
  output logic [11:0] back_voltage_o,
  output logic back_voltage_valid_o
);
  // Drive states as {high, low}
  localparam logic [5:0] DRV [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
  logic [2:0] st = 3'h0;
  logic [7:0] cnt = 8'h00;
  logic pend = 1'b0;

  assign back_voltage_o = bv_level_i;
  assign back_voltage_valid_o = 1'b1;

  always @(posedge mclk_i)
  begin
    phase_current_valid_o <= 1'b0;
    // Bus not driven between samples: invert it, so the last value shows only every other cycle
    phase_current_o <= ~phase_current_o;
    for (int k = 0; k < 6; k++)
      if ({high_gate_i, low_gate_i} == DRV[k])
        st <= 3'(k);
    if (adc_trigger_i)
    begin
      pend <= 1'b1;
      cnt <= delay_i;
    end
    else if (pend && cnt != 8'h00)
      cnt <= cnt - 8'h01;
    else if (pend)
    begin
      pend <= 1'b0;
      phase_current_valid_o <= 1'b1;
      phase_current_o <= cur_tbl_i[st];
    end
  end
endmodule : motor_power_stage

// ---- verif/sensorless_bldc_startup_chk.sv ----
// Assertion checker of the start-up sequencer, bound to its top module
`timescale 1ns/1ps

module sensorless_bldc_startup_chk #(
  parameter int unsigned MS_TICK_CYCLES = 10
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic adc_trigger_o,
  input wire logic [2:0] high_gate_o,
  input wire logic [2:0] low_gate_o,
  input wire logic busy_o,
  input wire logic handoff_valid_o,
  input wire logic [2:0] handoff_state_o
);
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // ------
  // Gate patterns
  // ------
  chk_single_high: assert property ($onehot0(high_gate_o))
    else $error("more than one high-side gate on");
  chk_no_shoot: assert property ((high_gate_o & low_gate_o) == 3'h0)
    else $error("high and low side of one phase both on");
  chk_pair_drive: assert property (high_gate_o != 3'h0 |-> $onehot(low_gate_o))
    else $error("driven state is not one high and one low phase");
  chk_spin_brake: assert property (low_gate_o == 3'h7 |-> high_gate_o == 3'h0 && busy_o)
    else $error("brake with a high side on or while idle");

  // ------
  // Probe pulse timing
  // ------
  chk_trig_withdraw: assert property (adc_trigger_o |-> high_gate_o == 3'h0
    && $past(high_gate_o) != 3'h0)
    else $error("conversion not started at pulse withdrawal");
  chk_brake_hold: assert property (adc_trigger_o |-> low_gate_o != 3'h0
    && $stable(low_gate_o))
    else $error("low side not kept on at pulse end");
  chk_trig_single: assert property (adc_trigger_o |=> !adc_trigger_o)
    else $error("conversion trigger longer than one cycle");
  chk_coast_next: assert property (high_gate_o == 3'h0 && $onehot(low_gate_o)
    |=> high_gate_o == 3'h0)
    else $error("next pulse without coast after brake");
  chk_handoff_one: assert property (handoff_valid_o
    |-> handoff_state_o < 3'h6 ##1 !handoff_valid_o)
    else $error("hand-off pulse too long or state out of range");

  cov_probe: cover property (adc_trigger_o);
  cov_brake: cover property (low_gate_o == 3'h7);
  cov_handoff: cover property (handoff_valid_o);
endmodule : sensorless_bldc_startup_chk

bind sensorless_bldc_startup sensorless_bldc_startup_chk #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) u_chk (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .adc_trigger_o(adc_trigger_o),
  .high_gate_o(high_gate_o),
  .low_gate_o(low_gate_o),
  .busy_o(busy_o),
  .handoff_valid_o(handoff_valid_o),
  .handoff_state_o(handoff_state_o)
);

// ---- verif/tb_sensorless_bldc_startup.sv ----
// Self-checking bench of the start-up sequencer
`timescale 1ns/1ps

module tb_sensorless_bldc_startup;
  // ------
  // Settings and signals
  // ------
  localparam int unsigned PC = 4;
  localparam int unsigned BC = 3;
  localparam int unsigned CC = 5;
  localparam logic [5:0] DRV [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
  typedef struct packed {logic [5:0] pat; logic [31:0] n;} seg_type;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rd_data;
  logic [11:0] bv;
  logic bv_ok;
  logic [11:0] pcur;
  logic pcur_ok;
  logic trig;
  logic [2:0] hg;
  logic [2:0] lg;
  logic busy;
  logic ho_v;
  logic [2:0] ho_st;
  logic [5:0][11:0] cur = '0;
  logic [7:0] dly = 8'h01;
  logic [11:0] bv_lvl = 12'h000;
  int miscompares = 0;
  int n_tests = 0;
  seg_type q [$];
  logic [5:0] pat = 6'h00;
  logic [31:0] len = 32'h0;

  always #5 mclk = ~mclk;

  sensorless_bldc_startup #(.MS_TICK_CYCLES(10)) uut (
    .mclk_i(mclk),
    .resetn_i(resetn),
    .addr_i(addr),
    .wr_data_i(wr_data),
    .wr_i(wr),
    .rd_i(rd),
    .rd_data_o(rd_data),
    .back_voltage_i(bv),
    .back_voltage_valid_i(bv_ok),
    .phase_current_i(pcur),
    .phase_current_valid_i(pcur_ok),
    .adc_trigger_o(trig),
    .high_gate_o(hg),
    .low_gate_o(lg),
    .busy_o(busy),
    .handoff_valid_o(ho_v),
    .handoff_state_o(ho_st)
  );

  motor_power_stage far (
    .mclk_i(mclk),
    .high_gate_i(hg),
    .low_gate_i(lg),
    .adc_trigger_i(trig),
    .cur_tbl_i(cur),
    .delay_i(dly),
    .bv_level_i(bv_lvl),
    .phase_current_o(pcur),
    .phase_current_valid_o(pcur_ok),
    .back_voltage_o(bv),
    .back_voltage_valid_o(bv_ok)
  );

  // Gate trace: one entry per run of equal gate levels
  always @(posedge mclk)
  begin
    if ({hg, lg} !== pat)
    begin
      q.push_back('{pat, len});
      pat = {hg, lg};
      len = 1;
    end
    else
      len++;
  end

  // ------
  // Tasks
  // ------
  task automatic conclude;
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rd_data, exp);
  endtask : rd_chk

  function automatic logic [31:0] exp_init(input logic [5:0][11:0] c);
    int b;
    int p;
    b = 0;
    for (int k = 1; k < 6; k++)
      if (c[k] > c[b])
        b = k;
    p = 2 * b + int'(c[(b + 1) % 6] > c[(b + 5) % 6]);
    return ((p + 3) / 2) % 6;
  endfunction : exp_init

  task automatic run(input logic [31:0] ctrl, output logic [2:0] st);
    q.delete();
    wr_reg(bldc_startup_pkg::REG_CTRL, ctrl);
    // Dropped: the sequencer is busy
    wr_reg(bldc_startup_pkg::REG_PULSE_CYC, 32'h9);
    if (ctrl[2])
    begin
      repeat (50) @(negedge mclk);
      chk(32'(q.size()), 0);
      @(posedge mclk);
      bv_lvl <= 12'h03f;
    end
    for (int i = 0; i < 20000 && ho_v !== 1'b1; i++)
      @(negedge mclk);
    if (ho_v !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    st = ho_st;
    rd_chk(bldc_startup_pkg::REG_STATUS, 32'h20002 | (32'(st) << 4));
    rd_chk(bldc_startup_pkg::REG_PULSE_CYC, PC);
  endtask : run

  task automatic probe(input logic [31:0] ctrl, input logic [2:0] ord [6]);
    logic [2:0] st;
    int b;
    run(ctrl, st);
    chk(st, exp_init(cur));
    b = 0;
    while (b < q.size() && q[b].pat[5:3] == 3'h0)
      b++;
    for (int i = 0; i < 6; i++)
    begin
      chk(q[b + 3 * i].pat, DRV[ord[i]]);
      chk(q[b + 3 * i].n, PC);
      chk(q[b + 3 * i + 1].pat, {3'h0, DRV[ord[i]][2:0]});
      chk(q[b + 3 * i + 1].n, BC);
      if (i < 5)
        chk({q[b + 3 * i + 2].pat, 1'b0}, {6'h0, 1'b0});
      if (i < 5)
        chk(32'(q[b + 3 * i + 2].n >= CC), 1);
    end
    for (int k = 0; k < 6; k++)
      rd_chk(bldc_startup_pkg::REG_RISE0 + 8'(k), 32'(cur[k]));
  endtask : probe

  // ------
  // Main sequence
  // ------
  initial
  begin
    logic [2:0] st;
    logic [31:0] dflt [11];
    logic [31:0] cfg [7];
    dflt = '{32'(bldc_startup_pkg::RST_CTRL), 32'h100, 32'(bldc_startup_pkg::RST_COAST_THRESH),
      32'(bldc_startup_pkg::RST_BRAKE_MS), 32'(bldc_startup_pkg::RST_PULSE_CYC),
      32'(bldc_startup_pkg::RST_PBRAKE_CYC), 32'(bldc_startup_pkg::RST_PCOAST_CYC),
      32'(bldc_startup_pkg::RST_ALIGN_CYC), 32'(bldc_startup_pkg::RST_SETTLE_CYC),
      32'(bldc_startup_pkg::RST_ORDER), 32'h0};
    cfg = '{32'h40, 32'h2, PC, BC, CC, 32'h6, 32'h4};
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    // Read-only place takes no write
    wr_reg(bldc_startup_pkg::REG_RISE0, 32'h5a5);
    for (int a = 0; a < 11; a++)
      rd_chk(8'(a), dflt[a]);
    rd_chk(bldc_startup_pkg::REG_RISE0, 32'h0);
    $display("test defaults done");
    for (int a = 0; a < 7; a++)
      wr_reg(bldc_startup_pkg::REG_COAST_THRESH + 8'(a), cfg[a]);
    cur = {12'h110, 12'h120, 12'h100, 12'h250, 12'h300, 12'h200};
    probe(32'h1, '{3'h0, 3'h3, 3'h1, 3'h4, 3'h2, 3'h5});
    $display("test probe default order done");
    // Slot holding 7 falls back to its own number; late samples stretch coast
    wr_reg(bldc_startup_pkg::REG_ORDER, 32'h1cbc1);
    dly <= 8'h0c;
    cur = {12'h200, 12'h3ff, 12'h280, 12'h120, 12'h110, 12'h100};
    probe(32'h1, '{3'h1, 3'h0, 3'h2, 3'h5, 3'h4, 3'h3});
    $display("test probe custom order done");
    dly <= 8'h01;
    bv_lvl <= 12'h040;
    probe(32'h5, '{3'h1, 3'h0, 3'h2, 3'h5, 3'h4, 3'h3});
    chk(q[1].pat, 6'h07);
    chk(32'(q[1].n >= 11 && q[1].n <= 21), 1);
    $display("test spin check done");
    for (int s = 0; s < 6; s++)
    begin
      run(32'h3 | (s << 4), st);
      chk(32'(q.size()), 2);
      chk(q[1].pat, DRV[s]);
      chk(q[1].n, 6);
      chk(st, (s + 2) % 6);
    end
    $display("test alignment done");
    conclude();
  end
endmodule : tb_sensorless_bldc_startup
